// ===== testbench/fsb_agent_model.sv
// Far-side bus agent: one two-subphase request per toggle of go_in.
// Assumes pins idle high by termination when released.
`timescale 1ns/1ps
module fsb_agent_model (
	input wire logic bclk_in,
	input wire logic go_in,
	input wire logic bad_in,
	input wire logic [35:3] addr_in,
	input wire logic [35:3] info_in,
	input wire logic [4:0] ta_in,
	input wire logic [4:0] tb_in,
	output logic [35:3] addr_n_out,
	output logic [4:0] req_n_out,
	output logic [1:0] par_n_out,
	output logic ads_n_out,
	output logic [1:0] stb_n_out
);
	logic seen = 1'b0;
	int ph = 0;
	initial {addr_n_out, req_n_out, par_n_out, ads_n_out, stb_n_out} = '1;
	always @(posedge bclk_in) begin
		#2;
		if (ph == 1) begin
			// Type subphase, strobes rise
			{addr_n_out, req_n_out, ads_n_out, stb_n_out} = {~info_in, ~tb_in, 1'b1, 2'h3};
			par_n_out = {~^info_in[35:24], ~^{tb_in, info_in[23:3]}};
			ph = 2;
		end else if (ph == 2) begin
			{addr_n_out, req_n_out, par_n_out, ads_n_out, stb_n_out} = '1;
			ph = 0;
		end else if (go_in != seen) begin
			seen = go_in;
			// Address subphase with valid strobe
			{addr_n_out, req_n_out, ads_n_out, stb_n_out} = {~addr_in, ~ta_in, 1'b0, 2'h0};
			par_n_out = {~^{ta_in, addr_in[23:3]}, (~^addr_in[35:24]) ^ bad_in};
			ph = 1;
		end
	end
endmodule

// ===== testbench/fsb_chk.sv
// Assertions on the request-phase block's pins and core handshake.
// Assumes binding to fsb_request_phase.
`timescale 1ns/1ps
module fsb_chk (
	input wire logic MCLK_IN,
	input wire logic NRST_IN,
	input wire logic BUS_CLOCK_IN,
	input wire logic REQ_VALID_IN,
	input wire logic REQ_READY_OUT,
	input wire logic [35:3] ADDR_N_OUT,
	input wire logic ADDR_N_OE_OUT,
	input wire logic [4:0] REQ_N_OUT,
	input wire logic [1:0] ADDR_PARITY_PAIR_N_OUT,
	input wire logic ADDR_VALID_STROBE_N_OUT,
	input wire logic [1:0] ADDR_SOURCE_STROBES_N_OUT,
	input wire logic SNOOP_VALID_OUT,
	input wire logic PARITY_ERROR_OUT
);
	logic ev_hi;
	logic ev_lo;
	assign ev_hi = ~^(~ADDR_N_OUT[35:24]);
	assign ev_lo = ~^(~{REQ_N_OUT, ADDR_N_OUT[23:3]});
	sequence s_sub1;
		ADDR_N_OE_OUT && !ADDR_VALID_STROBE_N_OUT && ADDR_SOURCE_STROBES_N_OUT == 2'h0;
	endsequence
	sequence s_sub2;
		ADDR_N_OE_OUT && ADDR_VALID_STROBE_N_OUT && ADDR_SOURCE_STROBES_N_OUT == 2'h3;
	endsequence
	property p_two_sub;
		@(posedge BUS_CLOCK_IN) disable iff (!NRST_IN)
		$fell(ADDR_VALID_STROBE_N_OUT) |-> s_sub1 ##1 s_sub2 ##1 !ADDR_N_OE_OUT;
	endproperty
	a_two_sub: assert property (p_two_sub) else $error("subphase sequence wrong");
	property p_par_sub1;
		@(posedge BUS_CLOCK_IN) disable iff (!NRST_IN) s_sub1 |-> ADDR_PARITY_PAIR_N_OUT == {ev_lo, ev_hi};
	endproperty
	a_par_sub1: assert property (p_par_sub1) else $error("parity wrong in subphase 1");
	property p_par_sub2;
		@(posedge BUS_CLOCK_IN) disable iff (!NRST_IN) s_sub2 |-> ADDR_PARITY_PAIR_N_OUT == {ev_hi, ev_lo};
	endproperty
	a_par_sub2: assert property (p_par_sub2) else $error("parity wrong in subphase 2");
	property p_idle;
		@(posedge BUS_CLOCK_IN) disable iff (!NRST_IN) !ADDR_N_OE_OUT |->
		ADDR_VALID_STROBE_N_OUT && ADDR_SOURCE_STROBES_N_OUT == 2'h3 && &ADDR_N_OUT && &REQ_N_OUT;
	endproperty
	a_idle: assert property (p_idle) else $error("pins not idle while released");
	property p_take;
		@(posedge MCLK_IN) disable iff (!NRST_IN) REQ_VALID_IN && REQ_READY_OUT |=> !REQ_READY_OUT;
	endproperty
	a_take: assert property (p_take) else $error("request not taken");
	property p_done;
		@(posedge MCLK_IN) disable iff (!NRST_IN) $fell(REQ_READY_OUT) |-> ##[1:150] REQ_READY_OUT;
	endproperty
	a_done: assert property (p_done) else $error("request never completed");
	property p_pulse;
		@(posedge MCLK_IN) disable iff (!NRST_IN) SNOOP_VALID_OUT |=> !SNOOP_VALID_OUT;
	endproperty
	a_pulse: assert property (p_pulse) else $error("capture pulse too long");
	property p_perr;
		@(posedge MCLK_IN) disable iff (!NRST_IN) PARITY_ERROR_OUT |-> SNOOP_VALID_OUT;
	endproperty
	a_perr: assert property (p_perr) else $error("parity error without capture");
endmodule

bind fsb_request_phase fsb_chk u_chk (.MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN), .BUS_CLOCK_IN(BUS_CLOCK_IN),
	.REQ_VALID_IN(REQ_VALID_IN), .REQ_READY_OUT(REQ_READY_OUT), .ADDR_N_OUT(ADDR_N_OUT),
	.ADDR_N_OE_OUT(ADDR_N_OE_OUT), .REQ_N_OUT(REQ_N_OUT), .ADDR_PARITY_PAIR_N_OUT(ADDR_PARITY_PAIR_N_OUT),
	.ADDR_VALID_STROBE_N_OUT(ADDR_VALID_STROBE_N_OUT), .ADDR_SOURCE_STROBES_N_OUT(ADDR_SOURCE_STROBES_N_OUT),
	.SNOOP_VALID_OUT(SNOOP_VALID_OUT), .PARITY_ERROR_OUT(PARITY_ERROR_OUT));

// ===== testbench/testbench.sv
// Bench: own and far-side requests, mask, parity error.
// Assumes the far side is fsb_agent_model on a free-running bus clock.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
	logic mclk = 1'b0, bclk = 1'b0, nrst = 1'b0, vld = 1'b0, mask_n = 1'b1, go = 1'b0, bad = 1'b0;
	logic [35:3] ra = '0, ri = '0, ma = 33'h0_ABCD_1234, mi = 33'h1_0F0F_7777, a_out, sa, si, a_w, m_a;
	logic [4:0] r_out, sta, stb_t, r_w, m_r;
	logic [1:0] p_out, s_out, p_w, s_w, m_p, m_s;
	logic rdy, a_oe, r_oe, p_oe, v_out, v_oe, s_oe, sv, perr, v_w, m_v;
	int bad_count = 0, samples_checked = 0;
	always #5 mclk = ~mclk;
	always #32 bclk = ~bclk;
	assign a_w = a_oe ? a_out : m_a;
	assign r_w = r_oe ? r_out : m_r;
	assign p_w = p_oe ? p_out : m_p;
	assign v_w = v_oe ? v_out : m_v;
	assign s_w = s_oe ? s_out : m_s;
	fsb_agent_model u_agent (.bclk_in(bclk), .go_in(go), .bad_in(bad), .addr_in(ma), .info_in(mi),
		.ta_in(5'h13), .tb_in(5'h0C), .addr_n_out(m_a), .req_n_out(m_r), .par_n_out(m_p),
		.ads_n_out(m_v), .stb_n_out(m_s));
	fsb_request_phase dut (.MCLK_IN(mclk), .NRST_IN(nrst), .BUS_CLOCK_IN(bclk), .REQ_VALID_IN(vld),
		.REQ_ADDR_IN(ra), .REQ_TYPE_A_IN(5'h0A), .REQ_INFO_IN(ri), .REQ_TYPE_B_IN(5'h15), .REQ_READY_OUT(rdy),
		.ADDR_BIT20_MASK_N_IN(mask_n), .ADDR_N_IN(a_w), .ADDR_N_OUT(a_out), .ADDR_N_OE_OUT(a_oe),
		.REQ_N_IN(r_w), .REQ_N_OUT(r_out), .REQ_N_OE_OUT(r_oe), .ADDR_PARITY_PAIR_N_IN(p_w),
		.ADDR_PARITY_PAIR_N_OUT(p_out), .ADDR_PARITY_PAIR_N_OE_OUT(p_oe), .ADDR_VALID_STROBE_N_IN(v_w),
		.ADDR_VALID_STROBE_N_OUT(v_out), .ADDR_VALID_STROBE_N_OE_OUT(v_oe), .ADDR_SOURCE_STROBES_N_IN(s_w),
		.ADDR_SOURCE_STROBES_N_OUT(s_out), .ADDR_SOURCE_STROBES_N_OE_OUT(s_oe), .SNOOP_VALID_OUT(sv),
		.SNOOP_ADDR_OUT(sa), .SNOOP_TYPE_A_OUT(sta), .SNOOP_INFO_OUT(si), .SNOOP_TYPE_B_OUT(stb_t),
		.PARITY_ERROR_OUT(perr));
	task final_report();
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task tick(input int n);
		@(posedge mclk);
		#1;
		if (n > 300) begin
			bad_count++;
			final_report();
		end
	endtask
	task expect_snoop(input logic [35:3] ea, ei, input logic [4:0] eta, etb, input logic ep);
		int n;
		n = 0;
		do begin
			tick(n++);
		end while (sv !== 1'b1);
		`CHK("snoop_addr", ea, sa)
		`CHK("snoop_info", ei, si)
		`CHK("snoop_type_a", eta, sta)
		`CHK("snoop_type_b", etb, stb_t)
		`CHK("parity_error", ep, perr)
	endtask
	task own_req(input logic [35:3] a, input logic m);
		logic [35:3] ea;
		int n;
		ea = a;
		if (!m)
			ea[20] = 1'b0;
		mask_n = m;
		ra = a;
		ri = ~a;
		n = 0;
		repeat (4) tick(0);
		while (rdy !== 1'b1) tick(n++);
		vld = 1'b1;
		tick(0);
		vld = 1'b0;
		expect_snoop(ea, ~a, 5'h0A, 5'h15, 1'b0);
	endtask
	task part_req(input logic bp);
		int n;
		n = 0;
		while (rdy !== 1'b1) tick(n++);
		bad = bp;
		go = ~go;
		expect_snoop(ma, mi, 5'h13, 5'h0C, bp);
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		#1;
		nrst = 1'b1;
		own_req(33'h1_5A5A_A5A5, 1'b1);
		own_req(33'h1_5A5A_A5A5, 1'b0);
		own_req(33'h0_0000_0000, 1'b1);
		own_req(33'h1_FFFF_FFFF, 1'b1);
		part_req(1'b0);
		part_req(1'b1);
		part_req(1'b0);
		final_report();
	end
endmodule

// ===== verilog/fsb_pkg.sv
// Shared constants for the bus request-phase address block.
// Assumes pins are active low at the pad and widths below fit the bus.
package fsb_pkg;

	localparam int ADDR_HI = 35;
	localparam int ADDR_LO = 3;
	localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
	localparam int REQ_W = 5;
	localparam int PIN_W = ADDR_W + REQ_W;
	localparam int MASK_BIT = 20;

	// Parity groups over {request lines, address lines}
	localparam logic [PIN_W-1:0] GRP_HI_SEL = 38'h01_FFE0_0000;
	localparam logic [PIN_W-1:0] GRP_LO_SEL = 38'h3E_001F_FFFF;

	// Reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 33'h0_0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_PIN_IDLE = 33'h1_FFFF_FFFF;
	localparam logic [REQ_W-1:0] REQ_RST = 5'h00;
	localparam logic [REQ_W-1:0] REQ_PIN_IDLE = 5'h1F;
	localparam logic [1:0] PAIR_PIN_IDLE = 2'h3;
	localparam logic [1:0] SYNC_IDLE_HI = 2'h3;
	localparam logic [1:0] SYNC_RST = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SUB1 = 3'b010,
		ST_SUB2 = 3'b100
	} fsb_tx_state_t;

endpackage

// ===== verilog/fsb_request_phase.sv
// Request-phase address logic of a front side bus agent: drives a two-subphase
// request with parity and strobes, and watches the bus for requests to snoop.
// Assumes BUS_CLOCK_IN is the single-ended output of the differential clock
// receiver and that bus ownership has already been won by other logic.
// Released pins are expected to float high through termination.
//
// Summary of operation
// RULE_01: Address lines carry quadword address bits 35..3.
// RULE_02: Subphase one carries address, subphase two type.
// RULE_03: Address lines captured by source strobes, not clock; code samples them on BUS_CLOCK_IN, kept at strobe edges.
// RULE_04: Strobes latch address and request lines, both edges; code uses only strobe 0's edges, strobe 1 is unused.
// RULE_05: Parity driven alongside valid strobe, address, request.
// RULE_06: Parity pin high when even count low.
// RULE_07: Parity coverage groups swap between the subphases.
// RULE_08: Valid strobe marks a valid address present.
// RULE_09: Valid strobe starts checking, decode and snoop.
// RULE_10: Mask input forces address bit 20 low.
// RULE_11: Mask is asserted only in real mode.
// RULE_12: Mask valid by target ready of I/O write.
// RULE_13: Differential bus clock drives outputs, latches inputs.
// RULE_14: Clock event is true rise crossing complement fall.
// RULE_15: Receiver recomputes parity and flags any mismatch.
`timescale 1ns/1ps

module fsb_request_phase (
	input wire logic MCLK_IN,
	input wire logic NRST_IN,
	input wire logic BUS_CLOCK_IN,
	input wire logic REQ_VALID_IN,
	input wire logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] REQ_ADDR_IN,
	input wire logic [fsb_pkg::REQ_W-1:0] REQ_TYPE_A_IN,
	input wire logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] REQ_INFO_IN,
	input wire logic [fsb_pkg::REQ_W-1:0] REQ_TYPE_B_IN,
	output logic REQ_READY_OUT,
	input wire logic ADDR_BIT20_MASK_N_IN,
	input wire logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] ADDR_N_IN,
	output logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] ADDR_N_OUT,
	output logic ADDR_N_OE_OUT,
	input wire logic [fsb_pkg::REQ_W-1:0] REQ_N_IN,
	output logic [fsb_pkg::REQ_W-1:0] REQ_N_OUT,
	output logic REQ_N_OE_OUT,
	input wire logic [1:0] ADDR_PARITY_PAIR_N_IN,
	output logic [1:0] ADDR_PARITY_PAIR_N_OUT,
	output logic ADDR_PARITY_PAIR_N_OE_OUT,
	input wire logic ADDR_VALID_STROBE_N_IN,
	output logic ADDR_VALID_STROBE_N_OUT,
	output logic ADDR_VALID_STROBE_N_OE_OUT,
	input wire logic [1:0] ADDR_SOURCE_STROBES_N_IN,
	output logic [1:0] ADDR_SOURCE_STROBES_N_OUT,
	output logic ADDR_SOURCE_STROBES_N_OE_OUT,
	output logic SNOOP_VALID_OUT,
	output logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] SNOOP_ADDR_OUT,
	output logic [fsb_pkg::REQ_W-1:0] SNOOP_TYPE_A_OUT,
	output logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] SNOOP_INFO_OUT,
	output logic [fsb_pkg::REQ_W-1:0] SNOOP_TYPE_B_OUT,
	output logic PARITY_ERROR_OUT
);

	// Pin level of a parity bit over the selected group of pin levels
	function automatic logic par_level(input logic [fsb_pkg::PIN_W-1:0] lv,
			input logic [fsb_pkg::PIN_W-1:0] sel);
		par_level = ~(^(~lv & sel)); // see RULE_06
	endfunction

	// Parity pair for one subphase; coverage swaps in subphase two
	function automatic logic [1:0] par_pair(input logic [fsb_pkg::PIN_W-1:0] lv, input logic second);
		if (second) begin
			par_pair = {par_level(lv, fsb_pkg::GRP_HI_SEL), par_level(lv, fsb_pkg::GRP_LO_SEL)}; // see RULE_07
		end else begin
			par_pair = {par_level(lv, fsb_pkg::GRP_LO_SEL), par_level(lv, fsb_pkg::GRP_HI_SEL)}; // see RULE_07
		end
	endfunction

	// A toggle seen between the last two flops of a sync chain
	function automatic logic toggle_seen(input logic [2:0] chain);
		toggle_seen = chain[2] != chain[1];
	endfunction

	// Core-domain state
	typedef struct packed {
		logic [1:0] mask_sync;
		logic ready;
		logic req_tgl;
		logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] req_addr;
		logic [fsb_pkg::REQ_W-1:0] req_type_a;
		logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] req_info;
		logic [fsb_pkg::REQ_W-1:0] req_type_b;
		// Sync chains from the bus domain, then the snoop hand-off words
		logic [2:0] done_sync;
		logic [2:0] cap_sync;
		logic snoop_valid;
		logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] snoop_addr;
		logic [fsb_pkg::REQ_W-1:0] snoop_type_a;
		logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] snoop_info;
		logic [fsb_pkg::REQ_W-1:0] snoop_type_b;
		logic perr;
	} fsb_core_t;

	// Bus-domain state, pins and capture
	typedef struct packed {
		fsb_pkg::fsb_tx_state_t st;
		logic [2:0] go_sync;
		logic done_tgl;
		logic drive_oe;
		logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] a_pin;
		logic [fsb_pkg::REQ_W-1:0] req_pin;
		logic [1:0] par_pin;
		logic ads_pin;
		logic [1:0] stb_pin;
		// Pin inputs two flops deep, strobe 0 three
		logic [1:0] ads_s;
		logic [1:0] stb_s1;
		logic [1:0] stb_s2;
		logic stb_d;
		logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] a_s1;
		logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] a_s2;
		logic [fsb_pkg::REQ_W-1:0] req_s1;
		logic [fsb_pkg::REQ_W-1:0] req_s2;
		logic [1:0] par_s1;
		logic [1:0] par_s2;
		// Capture progress and results held for the core
		logic rx_wait2;
		logic rx_err1;
		logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] rx_addr;
		logic [fsb_pkg::REQ_W-1:0] rx_type_a;
		logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] rx_info;
		logic [fsb_pkg::REQ_W-1:0] rx_type_b;
		logic rx_perr;
		logic cap_tgl;
	} fsb_bus_t;

	fsb_core_t core_r;
	fsb_core_t core_nxt;
	fsb_bus_t bus_r;
	fsb_bus_t bus_nxt;

	// Core domain: request intake, bit 20 masking, snoop hand-off
	always_comb begin
		logic [fsb_pkg::ADDR_HI:fsb_pkg::ADDR_LO] addr_m;
		addr_m = REQ_ADDR_IN;
		core_nxt = core_r;
		core_nxt.mask_sync = {core_r.mask_sync[0], ADDR_BIT20_MASK_N_IN};
		core_nxt.done_sync = {core_r.done_sync[1:0], bus_r.done_tgl};
		core_nxt.cap_sync = {core_r.cap_sync[1:0], bus_r.cap_tgl};

		// Sync chain already absorbs a late mask edge
		if (!core_r.mask_sync[1]) begin
			addr_m[fsb_pkg::MASK_BIT] = 1'b0; // see RULE_10
		end

		// Bus side reads these words only after the toggle arrives
		if (core_r.ready && REQ_VALID_IN) begin
			core_nxt.ready = 1'b0;
			core_nxt.req_tgl = ~core_r.req_tgl;
			core_nxt.req_addr = addr_m;
			core_nxt.req_type_a = REQ_TYPE_A_IN;
			core_nxt.req_info = REQ_INFO_IN;
			core_nxt.req_type_b = REQ_TYPE_B_IN;
		end

		// Ready returns once the bus side has released the pins
		if (toggle_seen(core_r.done_sync)) begin
			core_nxt.ready = 1'b1;
		end

		// Captured words stand still until the next toggle
		core_nxt.snoop_valid = 1'b0;
		core_nxt.perr = 1'b0;
		if (toggle_seen(core_r.cap_sync)) begin
			core_nxt.snoop_valid = 1'b1; // see RULE_09
			core_nxt.snoop_addr = bus_r.rx_addr;
			core_nxt.snoop_type_a = bus_r.rx_type_a;
			core_nxt.snoop_info = bus_r.rx_info;
			core_nxt.snoop_type_b = bus_r.rx_type_b;
			core_nxt.perr = bus_r.rx_perr; // see RULE_15
		end
	end

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			// Mask idles high so reset is never a masked state
			core_r.mask_sync <= fsb_pkg::SYNC_IDLE_HI;
			core_r.ready <= 1'b1;
			core_r.req_tgl <= 1'b0;
			core_r.req_addr <= fsb_pkg::ADDR_RST;
			core_r.req_type_a <= fsb_pkg::REQ_RST;
			core_r.req_info <= fsb_pkg::ADDR_RST;
			core_r.req_type_b <= fsb_pkg::REQ_RST;

			core_r.done_sync <= 3'h0;
			core_r.cap_sync <= 3'h0;

			core_r.snoop_valid <= 1'b0;
			core_r.snoop_addr <= fsb_pkg::ADDR_RST;
			core_r.snoop_type_a <= fsb_pkg::REQ_RST;
			core_r.snoop_info <= fsb_pkg::ADDR_RST;
			core_r.snoop_type_b <= fsb_pkg::REQ_RST;
			core_r.perr <= 1'b0;
		end else begin
			core_r <= core_nxt;
		end
	end

	// Bus domain: drive own request, capture every request seen on the bus
	always_comb begin
		logic [fsb_pkg::PIN_W-1:0] tx1;
		logic [fsb_pkg::PIN_W-1:0] tx2;
		logic [fsb_pkg::PIN_W-1:0] rx;
		logic fall;
		logic rise;
		fall = bus_r.stb_d && !bus_r.stb_s2[0];
		rise = !bus_r.stb_d && bus_r.stb_s2[0];
		// Pin levels of both subphases of the own request
		tx1 = {~core_r.req_type_a, ~core_r.req_addr};
		tx2 = {~core_r.req_type_b, ~core_r.req_info};
		rx = {bus_r.req_s2, bus_r.a_s2};
		bus_nxt = bus_r;

		// Pin inputs pass two flops; strobe 0 gets a third for edges
		bus_nxt.go_sync = {bus_r.go_sync[1:0], core_r.req_tgl};
		bus_nxt.ads_s = {bus_r.ads_s[0], ADDR_VALID_STROBE_N_IN};
		bus_nxt.stb_s1 = ADDR_SOURCE_STROBES_N_IN;
		bus_nxt.stb_s2 = bus_r.stb_s1;
		bus_nxt.stb_d = bus_r.stb_s2[0];
		bus_nxt.a_s1 = ADDR_N_IN;
		bus_nxt.a_s2 = bus_r.a_s1;
		bus_nxt.req_s1 = REQ_N_IN;
		bus_nxt.req_s2 = bus_r.req_s1;
		bus_nxt.par_s1 = ADDR_PARITY_PAIR_N_IN;
		bus_nxt.par_s2 = bus_r.par_s1;

		// Own request: address subphase, type subphase, then release
		unique case (bus_r.st)
			fsb_pkg::ST_IDLE: begin
				if (toggle_seen(bus_r.go_sync)) begin
					bus_nxt.st = fsb_pkg::ST_SUB1;
					bus_nxt.drive_oe = 1'b1;
					bus_nxt.a_pin = tx1[fsb_pkg::ADDR_W-1:0]; // see RULE_01
					bus_nxt.req_pin = tx1[fsb_pkg::PIN_W-1:fsb_pkg::ADDR_W]; // see RULE_02
					bus_nxt.par_pin = par_pair(tx1, 1'b0); // see RULE_05
					bus_nxt.ads_pin = 1'b0; // see RULE_08
					bus_nxt.stb_pin = 2'h0; // see RULE_04
				end
			end
			fsb_pkg::ST_SUB1: begin
				bus_nxt.st = fsb_pkg::ST_SUB2;
				bus_nxt.a_pin = tx2[fsb_pkg::ADDR_W-1:0]; // see RULE_02
				bus_nxt.req_pin = tx2[fsb_pkg::PIN_W-1:fsb_pkg::ADDR_W];
				bus_nxt.par_pin = par_pair(tx2, 1'b1); // see RULE_07
				bus_nxt.ads_pin = 1'b1;
				bus_nxt.stb_pin = fsb_pkg::PAIR_PIN_IDLE; // see RULE_04
			end
			fsb_pkg::ST_SUB2: begin
				bus_nxt.st = fsb_pkg::ST_IDLE;
				// Pins go back to their pulled-up idle level
				bus_nxt.drive_oe = 1'b0;
				bus_nxt.a_pin = fsb_pkg::ADDR_PIN_IDLE;
				bus_nxt.req_pin = fsb_pkg::REQ_PIN_IDLE;
				bus_nxt.par_pin = fsb_pkg::PAIR_PIN_IDLE;
				bus_nxt.done_tgl = ~bus_r.done_tgl;
			end
		endcase

		// Capture on strobe edges, started by the valid strobe
		if (!bus_r.ads_s[1] && fall) begin
			bus_nxt.rx_wait2 = 1'b1; // see RULE_09
			bus_nxt.rx_addr = ~bus_r.a_s2; // see RULE_03
			bus_nxt.rx_type_a = ~bus_r.req_s2;
			bus_nxt.rx_err1 = par_pair(rx, 1'b0) != bus_r.par_s2; // see RULE_15
		end else if (bus_r.rx_wait2 && rise) begin
			bus_nxt.rx_wait2 = 1'b0;
			bus_nxt.rx_info = ~bus_r.a_s2; // see RULE_04
			bus_nxt.rx_type_b = ~bus_r.req_s2;
			bus_nxt.rx_perr = bus_r.rx_err1 || (par_pair(rx, 1'b1) != bus_r.par_s2); // see RULE_15
			// Toggle on the same edge as the type-subphase words; the core's sync chain delays its read
			bus_nxt.cap_tgl = ~bus_r.cap_tgl;
		end
	end

	// Clock edge is the differential receiver's crossing point
	always_ff @(posedge BUS_CLOCK_IN or negedge NRST_IN) begin // see RULE_13, see RULE_14
		if (!NRST_IN) begin
			bus_r.st <= fsb_pkg::ST_IDLE;
			bus_r.go_sync <= 3'h0;
			bus_r.done_tgl <= 1'b0;
			bus_r.drive_oe <= 1'b0;

			bus_r.a_pin <= fsb_pkg::ADDR_PIN_IDLE;
			bus_r.req_pin <= fsb_pkg::REQ_PIN_IDLE;
			bus_r.par_pin <= fsb_pkg::PAIR_PIN_IDLE;
			bus_r.ads_pin <= 1'b1;
			bus_r.stb_pin <= fsb_pkg::PAIR_PIN_IDLE;

			// Strobe history idles high so release gives no false edge
			bus_r.ads_s <= fsb_pkg::SYNC_IDLE_HI;
			bus_r.stb_s1 <= fsb_pkg::SYNC_IDLE_HI;
			bus_r.stb_s2 <= fsb_pkg::SYNC_IDLE_HI;
			bus_r.stb_d <= 1'b1;
			bus_r.a_s1 <= fsb_pkg::ADDR_PIN_IDLE;
			bus_r.a_s2 <= fsb_pkg::ADDR_PIN_IDLE;
			bus_r.req_s1 <= fsb_pkg::REQ_PIN_IDLE;
			bus_r.req_s2 <= fsb_pkg::REQ_PIN_IDLE;
			bus_r.par_s1 <= fsb_pkg::PAIR_PIN_IDLE;
			bus_r.par_s2 <= fsb_pkg::PAIR_PIN_IDLE;

			bus_r.rx_wait2 <= 1'b0;
			bus_r.rx_err1 <= 1'b0;
			bus_r.rx_addr <= fsb_pkg::ADDR_RST;
			bus_r.rx_type_a <= fsb_pkg::REQ_RST;
			bus_r.rx_info <= fsb_pkg::ADDR_RST;
			bus_r.rx_type_b <= fsb_pkg::REQ_RST;
			bus_r.rx_perr <= 1'b0;
			bus_r.cap_tgl <= 1'b0;
		end else begin
			bus_r <= bus_nxt;
		end
	end

	// Every output is a register; pins below are bus-domain
	assign REQ_READY_OUT = core_r.ready;
	assign ADDR_N_OUT = bus_r.a_pin;
	assign ADDR_N_OE_OUT = bus_r.drive_oe;
	assign REQ_N_OUT = bus_r.req_pin;
	assign REQ_N_OE_OUT = bus_r.drive_oe;
	assign ADDR_PARITY_PAIR_N_OUT = bus_r.par_pin;
	assign ADDR_PARITY_PAIR_N_OE_OUT = bus_r.drive_oe;

	assign ADDR_VALID_STROBE_N_OUT = bus_r.ads_pin;
	assign ADDR_VALID_STROBE_N_OE_OUT = bus_r.drive_oe;
	assign ADDR_SOURCE_STROBES_N_OUT = bus_r.stb_pin;
	assign ADDR_SOURCE_STROBES_N_OE_OUT = bus_r.drive_oe;

	// Snoop hand-off, core domain
	assign SNOOP_VALID_OUT = core_r.snoop_valid;
	assign SNOOP_ADDR_OUT = core_r.snoop_addr;
	assign SNOOP_TYPE_A_OUT = core_r.snoop_type_a;
	assign SNOOP_INFO_OUT = core_r.snoop_info;
	assign SNOOP_TYPE_B_OUT = core_r.snoop_type_b;
	assign PARITY_ERROR_OUT = core_r.perr;

endmodule
